// ### rtl/rio_pkg.sv
// Shared constants and types for the remote I/O expander port.
// Assumes a single synchronous clock domain and synchronous reset.
package rio_pkg;
   localparam int GROUP_W     = 16;
   localparam int MAX_GROUPS  = 2;
   localparam int MAX_POINTS  = GROUP_W * MAX_GROUPS;
   localparam int GSEL_W      = 1;
   localparam logic [GROUP_W-1:0] OUT_RESET = 16'h0000;
   localparam logic [GROUP_W-1:0] DATA_ZERO = 16'h0000;

   typedef enum logic [2:0] {
      OP_WRITE   = 3'b000,
      OP_AND     = 3'b001,
      OP_OR      = 3'b010,
      OP_READ_IN = 3'b011,
      OP_READ_IO = 3'b100
   } op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RESP = 1'b1
   } state_t;
endpackage : rio_pkg

// ### rtl/io_group_merge.sv
// Next value of one 16-point output group for a write, AND or OR command.
// Assumes the caller qualifies apply with an accepted command for this group.
`timescale 1ns/10ps
`default_nettype none
module io_group_merge
   import rio_pkg::*;
(
   input  wire logic [GROUP_W-1:0] current,
   input  wire logic [GROUP_W-1:0] data,
   input  wire logic [2:0]         op,
   input  wire logic               apply,
   output logic      [GROUP_W-1:0] next_group
);
   wire logic [GROUP_W-1:0] andValue;
   wire logic [GROUP_W-1:0] orValue;
   wire logic [GROUP_W-1:0] mergeValue;

   assign andValue = current & data;
   assign orValue  = current | data;

   assign mergeValue = (op == OP_WRITE) ? data :
                       (op == OP_AND)   ? andValue :
                       (op == OP_OR)    ? orValue : current;

   assign next_group = apply ? mergeValue : current;
endmodule : io_group_merge
`default_nettype wire

// ### rtl/remote_io_expander_port.sv
// Device-side core of the remote I/O expander: 16 or 32 points in and out.
// Assumes the link decoder delivers commands on a valid/ready port and takes
// answers on a valid/ready port; pins are synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module remote_io_expander_port
   import rio_pkg::*;
#(
   parameter int NUM_GROUPS = MAX_GROUPS
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  cmdValid,
   output logic                       cmdReady,
   input  wire logic [2:0]            cmdOp,
   input  wire logic [GSEL_W-1:0]     cmdGroup,
   input  wire logic [GROUP_W-1:0]    cmdData,
   output logic                       rspValid,
   input  wire logic                  rspReady,
   output logic      [GROUP_W-1:0]    rspInData,
   output logic      [GROUP_W-1:0]    rspOutData,
   output logic                       rspError,
   input  wire logic [MAX_POINTS-1:0] gpIn,
   output logic      [MAX_POINTS-1:0] gpOutOn
);

   function automatic logic [GROUP_W-1:0] pickGroup(input logic [MAX_POINTS-1:0] vec,
                                                    input logic [GSEL_W-1:0]     sel);
      pickGroup = vec[sel*GROUP_W +: GROUP_W];
   endfunction : pickGroup

   state_t                  state;
   state_t                  next_state;
   logic [MAX_POINTS-1:0]   outState;
   logic [MAX_POINTS-1:0]   inSample;
   logic [GROUP_W-1:0]      rspIn;
   logic [GROUP_W-1:0]      rspOut;
   logic                    rspErr;

   wire logic                  accept;
   wire logic                  groupOk;
   wire logic                  opWrite;
   wire logic                  opRead;
   wire logic                  opKnown;
   wire logic                  cmdBad;
   wire logic [MAX_POINTS-1:0] next_outState;
   wire logic [MAX_POINTS-1:0] fittedIn;
   wire logic [GROUP_W-1:0]    next_rspIn;
   wire logic [GROUP_W-1:0]    next_rspOut;

   assign cmdReady = (state == ST_IDLE);
   assign accept   = cmdValid && cmdReady;
   assign groupOk  = (32'(cmdGroup) < NUM_GROUPS);
   assign opWrite  = (cmdOp == OP_WRITE) || (cmdOp == OP_AND) || (cmdOp == OP_OR);
   assign opRead   = (cmdOp == OP_READ_IN) || (cmdOp == OP_READ_IO);
   assign opKnown  = opWrite || opRead;
   assign cmdBad   = !groupOk || !opKnown;

   genvar g;
   generate
      for (g = 0; g < MAX_GROUPS; g = g + 1) begin : gGroup
         if (g < NUM_GROUPS) begin : gLive
            io_group_merge uMerge (
               .current    (outState[g*GROUP_W +: GROUP_W]),
               .data       (cmdData),
               .op         (cmdOp),
               .apply      (accept && opWrite && !cmdBad && (32'(cmdGroup) == g)),
               .next_group (next_outState[g*GROUP_W +: GROUP_W])
            );
            assign fittedIn[g*GROUP_W +: GROUP_W] = gpIn[g*GROUP_W +: GROUP_W];
         end else begin : gAbsent
            assign next_outState[g*GROUP_W +: GROUP_W] = OUT_RESET;
            assign fittedIn[g*GROUP_W +: GROUP_W]      = DATA_ZERO;
         end
      end
   endgenerate

   assign next_rspIn  = (!cmdBad && opRead) ? pickGroup(inSample, cmdGroup) : DATA_ZERO;
   assign next_rspOut = (!cmdBad && cmdOp == OP_READ_IO) ?
                        pickGroup(outState, cmdGroup) : DATA_ZERO;

   always_comb begin
      case (state)
         ST_IDLE: next_state = accept ? ST_RESP : ST_IDLE;
         ST_RESP: next_state = rspReady ? ST_IDLE : ST_RESP;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Outputs and input sample
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         outState <= {MAX_GROUPS{OUT_RESET}};
         inSample <= {MAX_GROUPS{DATA_ZERO}};
      end else begin
         outState <= next_outState;
         inSample <= fittedIn;
      end
   end

   // Answer held until taken
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rspIn  <= DATA_ZERO;
         rspOut <= DATA_ZERO;
         rspErr <= 1'b0;
      end else if (accept) begin
         rspIn  <= next_rspIn;
         rspOut <= next_rspOut;
         rspErr <= cmdBad;
      end
   end

   assign rspValid   = (state == ST_RESP);
   assign rspInData  = rspIn;
   assign rspOutData = rspOut;
   assign rspError   = rspErr;
   assign gpOutOn    = outState;

   // Checks
   sequence s_andCmd;
      accept && cmdOp == OP_AND && !cmdBad;
   endsequence

   sequence s_orCmd;
      accept && cmdOp == OP_OR && !cmdBad;
   endsequence

   sequence s_readIo;
      accept && cmdOp == OP_READ_IO && !cmdBad;
   endsequence

   a_and_clears: assert property (
      @(posedge clk_sys) disable iff (srst)
      s_andCmd |=> (pickGroup(gpOutOn, $past(cmdGroup)) & ~$past(cmdData)) == DATA_ZERO)
      else $error("AND merge left a zero bit on");

   a_and_keeps: assert property (
      @(posedge clk_sys) disable iff (srst)
      s_andCmd |=> (pickGroup(gpOutOn, $past(cmdGroup)) & $past(cmdData)) ==
                   (pickGroup($past(gpOutOn), $past(cmdGroup)) & $past(cmdData)))
      else $error("AND merge changed a one bit");

   a_or_keeps: assert property (
      @(posedge clk_sys) disable iff (srst)
      s_orCmd |=> (pickGroup(gpOutOn, $past(cmdGroup)) & ~$past(cmdData)) ==
                  (pickGroup($past(gpOutOn), $past(cmdGroup)) & ~$past(cmdData)))
      else $error("OR merge changed a zero bit");

   a_or_sets: assert property (
      @(posedge clk_sys) disable iff (srst)
      s_orCmd |=> (pickGroup(gpOutOn, $past(cmdGroup)) & $past(cmdData)) == $past(cmdData))
      else $error("OR merge left a one bit off");

   a_write_group: assert property (
      @(posedge clk_sys) disable iff (srst)
      (accept && cmdOp == OP_WRITE && !cmdBad) |=>
         pickGroup(gpOutOn, $past(cmdGroup)) == $past(cmdData) &&
         pickGroup(gpOutOn, ~$past(cmdGroup)) == pickGroup($past(gpOutOn), ~$past(cmdGroup)))
      else $error("Plain write did not replace exactly one group");

   a_read_input: assert property (
      @(posedge clk_sys) disable iff (srst)
      (accept && cmdOp == OP_READ_IN && !cmdBad) |=>
         rspValid && rspInData == pickGroup($past(inSample), $past(cmdGroup)) &&
         rspOutData == DATA_ZERO)
      else $error("Input read answer wrong");

   a_read_both: assert property (
      @(posedge clk_sys) disable iff (srst)
      s_readIo |=> rspValid && !rspError &&
                   rspOutData == pickGroup(gpOutOn, $past(cmdGroup)))
      else $error("Combined read output group wrong");

   a_absent_group: assert property (
      @(posedge clk_sys) disable iff (srst)
      (accept && !groupOk) |=> rspError && $stable(gpOutOn))
      else $error("Absent group not refused");

   a_answer_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
      (rspValid && !rspReady) |=> rspValid && $stable(rspInData) && !cmdReady)
      else $error("Answer dropped before taken");

endmodule : remote_io_expander_port
`default_nettype wire

// ### testbench/host_link_model.sv
// Host-side link model: offers one command, then collects its answer.
// Assumes the core accepts at a rising edge with cmdValid and cmdReady high.
`timescale 1ns/10ps
`default_nettype none
module host_link_model
   import rio_pkg::*;
(
   input  wire logic               clk_sys,
   output logic                    cmdValid,
   input  wire logic               cmdReady,
   output logic      [2:0]         cmdOp,
   output logic      [GSEL_W-1:0]  cmdGroup,
   output logic      [GROUP_W-1:0] cmdData,
   input  wire logic               rspValid,
   output logic                    rspReady,
   input  wire logic [GROUP_W-1:0] rspInData,
   input  wire logic [GROUP_W-1:0] rspOutData,
   input  wire logic               rspError
);
   initial begin
      cmdValid = 1'b0;
      rspReady = 1'b0;
      cmdOp    = 3'h0;
      cmdGroup = 1'h0;
      cmdData  = 16'h0000;
   end
   task automatic xfer(input logic [2:0] op, input logic [GSEL_W-1:0] grp,
      input logic [GROUP_W-1:0] data, input int stall,
      output logic [GROUP_W-1:0] inD, output logic [GROUP_W-1:0] outD, output logic err);
      int   n;
      logic lost;
      n = 0;
      lost = 1'b0;
      cmdValid <= 1'b1;
      cmdOp    <= op;
      cmdGroup <= grp;
      cmdData  <= data;
      // Request stands until an edge sees ready high
      do @(posedge clk_sys); while (!cmdReady && ++n < 50);
      if (!cmdReady) lost = 1'b1;
      cmdValid <= 1'b0;
      // Released op and data lines carry no stale value; cmdGroup keeps its value
      cmdOp    <= ~op;
      cmdData  <= ~data;
      repeat (stall) @(posedge clk_sys);
      rspReady <= 1'b1;
      // Answer taken at the edge that completes the handshake
      do @(posedge clk_sys); while (!rspValid && ++n < 100);
      if (!rspValid) lost = 1'b1;
      inD  = rspInData;
      outD = rspOutData;
      err  = rspError;
      // Lost handshake shows as unknown error flag
      if (lost) err = 1'bx;
      rspReady <= 1'b0;
   endtask : xfer
endmodule : host_link_model
`default_nettype wire

// ### testbench/tb_remote_io_expander_port.sv
// Self-checking bench for the 32-point expander core.
// Assumes host_link_model drives both handshakes.
`timescale 1ns/10ps
`default_nettype none
module tb_remote_io_expander_port;
   import rio_pkg::*;
   logic               clk_sys, srst, cmdValid, cmdReady, rspValid, rspReady, rspError, err;
   logic [2:0]         cmdOp;
   logic [GSEL_W-1:0]  cmdGroup;
   logic [GROUP_W-1:0] cmdData, rspInData, rspOutData, inD, outD;
   logic [31:0]        gpIn, gpOutOn, gpOutNarrow;
   logic               errNarrow;
   int                 failures = 0;
   int                 cmp_count = 0;

   remote_io_expander_port dut (.clk_sys(clk_sys), .srst(srst), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdGroup(cmdGroup), .cmdData(cmdData),
      .rspValid(rspValid), .rspReady(rspReady), .rspInData(rspInData),
      .rspOutData(rspOutData), .rspError(rspError), .gpIn(gpIn), .gpOutOn(gpOutOn));
   host_link_model host (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdOp(cmdOp), .cmdGroup(cmdGroup), .cmdData(cmdData), .rspValid(rspValid),
      .rspReady(rspReady), .rspInData(rspInData), .rspOutData(rspOutData),
      .rspError(rspError));
   // Sixteen-point variant in lockstep on the same command stream
   remote_io_expander_port #(.NUM_GROUPS(1)) dutNarrow (.clk_sys(clk_sys), .srst(srst),
      .cmdValid(cmdValid), .cmdReady(), .cmdOp(cmdOp), .cmdGroup(cmdGroup),
      .cmdData(cmdData), .rspValid(), .rspReady(rspReady), .rspInData(), .rspOutData(),
      .rspError(errNarrow), .gpIn(gpIn), .gpOutOn(gpOutNarrow));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   task automatic send(input logic [2:0] op, input logic [GSEL_W-1:0] grp,
      input logic [GROUP_W-1:0] data, input int stall, input logic expErr);
      host.xfer(op, grp, data, stall, inD, outD, err);
      chk({31'h0, err}, {31'h0, expErr});
   endtask : send

   task automatic t_write();
      send(OP_WRITE, 1'b0, 16'hA5C3, 0, 1'b0);
      send(OP_WRITE, 1'b1, 16'h3C5A, 2, 1'b0);
      chk(gpOutOn, 32'h3C5AA5C3);
      chk(gpOutNarrow, 32'h0000A5C3);
      chk({31'h0, errNarrow}, 32'h1);
      $display("test write done");
   endtask : t_write

   task automatic t_merge();
      send(OP_AND, 1'b0, 16'hF0F0, 0, 1'b0);
      chk(gpOutOn, 32'h3C5AA0C0);
      send(OP_OR, 1'b1, 16'h0181, 3, 1'b0);
      chk(gpOutOn, 32'h3DDBA0C0);
      chk(gpOutNarrow, 32'h0000A0C0);
      chk({31'h0, errNarrow}, 32'h1);
      $display("test merge done");
   endtask : t_merge

   task automatic t_read();
      gpIn <= 32'h1234ABCD;
      repeat (3) @(posedge clk_sys);
      send(OP_READ_IN, 1'b1, 16'h0000, 1, 1'b0);
      chk({inD, outD}, 32'h12340000);
      send(OP_READ_IO, 1'b0, 16'h0000, 0, 1'b0);
      chk({inD, outD}, 32'hABCDA0C0);
      $display("test read done");
   endtask : t_read

   task automatic t_bad();
      send(3'h7, 1'b0, 16'h0000, 0, 1'b1);
      chk(gpOutOn, 32'h3DDBA0C0);
      chk({31'h0, errNarrow}, 32'h1);
      chk(gpOutNarrow, 32'h0000A0C0);
      $display("test refused op done");
   endtask : t_bad

   initial begin
      srst = 1'b1;
      gpIn = 32'h0;
      repeat (5) @(posedge clk_sys);
      chk(gpOutOn, 32'h0);
      chk(gpOutNarrow, 32'h0);
      srst <= 1'b0;
      t_write();
      t_merge();
      t_read();
      t_bad();
      conclude();
   end

   initial begin
      #(25 * 2000);
      failures++;
      conclude();
   end
endmodule : tb_remote_io_expander_port
`default_nettype wire
